//--- hw/msc_error_capture_defines.vh
// Constants for the error capture block: status word layout, error codes,
// access kinds and reset values.
// Assumes it is included by its bare name from the design file.
`ifndef MSC_ERROR_CAPTURE_DEFINES_VH
`define MSC_ERROR_CAPTURE_DEFINES_VH

// Status word field positions.
`define ESR_OVR_BIT        31
`define ESR_CODE_HI        27
`define ESR_CODE_LO        24
`define ESR_GRP_HI         23
`define ESR_GRP_LO         16
`define ESR_ID_HI          15
`define ESR_ID_LO          0

// Error codes written into the code field.
`define ERR_NONE           4'h0
`define ERR_SEL_RANGE      4'h1
`define ERR_REQ_PART_RANGE 4'h2
`define ERR_MON_CFG_ID     4'h3
`define ERR_REQ_GRP_RANGE  4'h4
`define ERR_MON_RANGE      4'h5
`define ERR_NARROW_RANGE   4'h6
`define ERR_UNEXP_INTERNAL 4'h7

// Kinds of configuration register access.
`define KIND_OTHER         2'h0
`define KIND_PART_CFG      2'h1
`define KIND_NARROW_MAP    2'h2
`define KIND_MON_CFG       2'h3

// Reset values and substitute identifiers.
`define ESR_RESET          32'h0000_0000
`define DEFAULT_PARTITION  16'h0000
`define DEFAULT_GROUP      8'h00

`endif

//--- hw/msc_error_capture.v
// Error detection and syndrome capture for a memory-system component.
// Assumes all inputs come from logic on clk_sys_in; the configuration
// access and request strobes are one-cycle pulses.
//
// Operation
// - Register access errors record a syndrome and raise the error interrupt.
// - Errors never stop a request or access from being serviced, except stores that hit code 1 or 5.
// - Code 1 for out-of-range partition selector on store; captures partition.
// - Code 2 for request partition out of range; captures partition and group.
// - Code 3 for monitor config write with bad partition or group.
// - Code 4 for request group out of range; captures partition and group.
// - Code 5 for monitor store with out-of-range monitor index.
// - Code 6 for bad narrowed value, clear map flag, or clear selector flag.
// - Code 7 when selector flag is set on map register access.
// - Codes 6 and 7 only arise when narrowing is present.
// - Codes 8 to 15 are never produced.
// - Bank chosen by access security bit or request security bit.
// - Out-of-range partition requests use the default partition.
// - Requests with only the group out of range use default group and skip monitoring.
// - Every error overwrites status; overwritten flag set if code was nonzero. A config error in the same cycle as a request error to its bank is lost.
// - Hardware never produces overwritten flag with code zero.
// - An erroneous configuration read may return any value.
// - Store with bad partition selector may be dropped.
// - Other partition write errors may leave selected settings unknown.
// - Store with bad monitor index may be dropped.
// - Other monitor write errors may leave selected monitor unknown.
// - Interrupt only while the bank's enable bit is set.
// - Status layout: flag 31, code 27:24, group 23:16, identifier 15:0.
// - Identifier fields not captured by the error type are written zero.
`include "msc_error_capture_defines.vh"

module msc_error_capture #(
    parameter [15:0] PARTID_MAX_S    = 16'h00ff,
    parameter [15:0] PARTID_MAX_NS   = 16'h00ff,
    parameter [7:0]  GROUP_MAX_S     = 8'h01,
    parameter [7:0]  GROUP_MAX_NS    = 8'h01,
    parameter [15:0] NARROW_MAX_S    = 16'h000f,
    parameter [15:0] NARROW_MAX_NS   = 16'h000f,
    parameter [15:0] MONITOR_MAX     = 16'h0007,
    parameter        NARROW_PRESENT  = 1
) (
    input  wire        clk_sys_in,
    input  wire        rst_in,
    // Configuration register access.
    input  wire        cfg_valid_in,
    input  wire        cfg_write_in,
    input  wire        cfg_ns_in,
    input  wire [1:0]  cfg_kind_in,
    input  wire [15:0] partition_selector_in,
    input  wire        selector_internal_in,
    input  wire [15:0] narrowed_partition_field_in,
    input  wire        map_internal_in,
    input  wire [15:0] monitor_index_field_in,
    input  wire [15:0] mon_cfg_partition_in,
    input  wire [7:0]  mon_cfg_group_in,
    input  wire [31:0] cfg_rdata_in,
    output reg         cfg_done_out,
    output reg         cfg_apply_out,
    output reg         cfg_error_out,
    output reg  [31:0] cfg_rdata_out,
    // Tagged requests.
    input  wire        req_valid_in,
    input  wire        request_security_bit_in,
    input  wire [15:0] request_partition_id_in,
    input  wire [7:0]  req_group_in,
    output reg         req_valid_out,
    output reg         req_ns_out,
    output reg  [15:0] req_partition_out,
    output reg  [7:0]  req_group_out,
    output reg         req_mon_exclude_out,
    // Software access to the banked status and control bits.
    input  wire        error_irq_enable_s_in,
    input  wire        error_irq_enable_ns_in,
    input  wire        esr_write_s_in,
    input  wire        esr_write_ns_in,
    input  wire [31:0] esr_wdata_in,
    output wire [31:0] error_status_register_s_out,
    output wire [31:0] error_status_register_ns_out,
    output wire        narrowing_present_out,
    output reg         error_irq_out
);

    // Range checks against the limits of the access's security space.
    wire [15:0] part_max_cfg   = cfg_ns_in ? PARTID_MAX_NS : PARTID_MAX_S;
    wire [7:0]  grp_max_cfg    = cfg_ns_in ? GROUP_MAX_NS : GROUP_MAX_S;
    wire [15:0] narrow_max_cfg = cfg_ns_in ? NARROW_MAX_NS : NARROW_MAX_S;
    wire [15:0] part_max_req   = request_security_bit_in ? PARTID_MAX_NS
                                                         : PARTID_MAX_S;
    wire [7:0]  grp_max_req    = request_security_bit_in ? GROUP_MAX_NS
                                                         : GROUP_MAX_S;
    wire        narrowing      = (NARROW_PRESENT != 0);

    wire sel_bad    = partition_selector_in > part_max_cfg;
    wire narrow_bad = narrowed_partition_field_in > narrow_max_cfg;
    wire mon_bad    = monitor_index_field_in > MONITOR_MAX;
    wire mcp_bad    = mon_cfg_partition_in > part_max_cfg;
    wire mcg_bad    = mon_cfg_group_in > grp_max_cfg;
    wire rq_p_bad   = request_partition_id_in > part_max_req;
    wire rq_g_bad   = req_group_in > grp_max_req;

    // Configuration error decode: one code per access at most.
    reg  [3:0]  cfg_code;
    reg  [7:0]  cfg_grp;
    reg  [15:0] cfg_id;
    reg         cfg_drop;

    always @* begin
        cfg_code = `ERR_NONE;
        cfg_grp  = `DEFAULT_GROUP;
        cfg_id   = 16'h0000;
        cfg_drop = 1'b0;
        if (cfg_valid_in) begin
            case (cfg_kind_in)
                `KIND_NARROW_MAP: begin
                    if (narrowing && selector_internal_in) begin
                        cfg_code = `ERR_UNEXP_INTERNAL;
                        cfg_id   = partition_selector_in;
                    end else if (cfg_write_in && sel_bad) begin
                        cfg_code = `ERR_SEL_RANGE;
                        cfg_id   = partition_selector_in;
                        cfg_drop = 1'b1;
                    end else if (narrowing && cfg_write_in &&
                                 (!map_internal_in || narrow_bad)) begin
                        cfg_code = `ERR_NARROW_RANGE;
                        cfg_id   = narrowed_partition_field_in;
                    end
                end
                `KIND_PART_CFG: begin
                    if (narrowing && !selector_internal_in) begin
                        cfg_code = `ERR_NARROW_RANGE;
                        cfg_id   = partition_selector_in;
                    end else if (cfg_write_in && sel_bad) begin
                        cfg_code = `ERR_SEL_RANGE;
                        cfg_id   = partition_selector_in;
                        cfg_drop = 1'b1;
                    end
                end
                `KIND_MON_CFG: begin
                    if (cfg_write_in && mon_bad) begin
                        cfg_code = `ERR_MON_RANGE;
                        cfg_id   = monitor_index_field_in;
                        cfg_drop = 1'b1;
                    end else if (cfg_write_in && (mcp_bad || mcg_bad)) begin
                        cfg_code = `ERR_MON_CFG_ID;
                        cfg_id   = mon_cfg_partition_in;
                        cfg_grp  = mon_cfg_group_in;
                    end
                end
                default: begin
                    cfg_code = `ERR_NONE;
                end
            endcase
        end
    end

    // Request error decode; partition range takes precedence over group.
    reg [3:0] req_code;

    always @* begin
        req_code = `ERR_NONE;
        if (req_valid_in) begin
            if (rq_p_bad) begin
                req_code = `ERR_REQ_PART_RANGE;
            end else if (rq_g_bad) begin
                req_code = `ERR_REQ_GRP_RANGE;
            end
        end
    end

    wire        cfg_err  = (cfg_code != `ERR_NONE);
    wire        req_err  = (req_code != `ERR_NONE);
    // Only three code bits are carried, so reserved codes cannot reach the
    // status word even if the decode above is extended later.
    wire [31:0] cfg_synd = {4'h0, 1'b0, cfg_code[2:0],
                            cfg_grp, cfg_id};
    wire [31:0] req_synd = {4'h0, 1'b0, req_code[2:0],
                            req_group_in,
                            request_partition_id_in};

    // Banked status registers, one bank for each security space. The next
    // value is exported so that the interrupt level moves on the same edge
    // as the status word and not one cycle behind it.
    wire [31:0] esr_s_r;
    wire [31:0] esr_ns_r;
    wire [31:0] esr_s_nxt;
    wire [31:0] esr_ns_nxt;

    wire cfg_hit_s  = cfg_err && !cfg_ns_in;
    wire cfg_hit_ns = cfg_err && cfg_ns_in;
    wire req_hit_s  = req_err && !request_security_bit_in;
    wire req_hit_ns = req_err && request_security_bit_in;

    msc_esr_bank #(
        .RESET_VALUE (`ESR_RESET)
    ) esr_bank_s_inst (
        .clk_sys_in  (clk_sys_in),
        .rst_in      (rst_in),
        .sw_write_in (esr_write_s_in),
        .sw_data_in  (esr_wdata_in),
        .cfg_hit_in  (cfg_hit_s),
        .cfg_synd_in (cfg_synd),
        .req_hit_in  (req_hit_s),
        .req_synd_in (req_synd),
        .esr_nxt_out (esr_s_nxt),
        .esr_out     (esr_s_r)
    );

    msc_esr_bank #(
        .RESET_VALUE (`ESR_RESET)
    ) esr_bank_ns_inst (
        .clk_sys_in  (clk_sys_in),
        .rst_in      (rst_in),
        .sw_write_in (esr_write_ns_in),
        .sw_data_in  (esr_wdata_in),
        .cfg_hit_in  (cfg_hit_ns),
        .cfg_synd_in (cfg_synd),
        .req_hit_in  (req_hit_ns),
        .req_synd_in (req_synd),
        .esr_nxt_out (esr_ns_nxt),
        .esr_out     (esr_ns_r)
    );

    wire irq_s   = error_irq_enable_s_in &&
                   (esr_s_nxt[`ESR_CODE_HI:`ESR_CODE_LO] != `ERR_NONE);
    wire irq_ns  = error_irq_enable_ns_in &&
                   (esr_ns_nxt[`ESR_CODE_HI:`ESR_CODE_LO] != `ERR_NONE);
    wire irq_nxt = irq_s || irq_ns;

    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            error_irq_out <= 1'b0;
        end else begin
            // Level output: held while enabled and a code stands.
            error_irq_out <= irq_nxt;
        end
    end

    // Configuration answer. A write that hit a selector or monitor index range
    // error is dropped rather than steered elsewhere, which keeps other partitions
    // and monitors intact; other erroring writes still apply.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_done_out  <= 1'b0;
            cfg_apply_out <= 1'b0;
            cfg_error_out <= 1'b0;
            cfg_rdata_out <= 32'h0000_0000;
        end else begin
            cfg_done_out  <= cfg_valid_in;
            cfg_apply_out <= cfg_valid_in && cfg_write_in &&
                             !cfg_drop;
            cfg_error_out <= cfg_err;
            if (cfg_valid_in && !cfg_write_in) begin
                // Erroring reads answer zero, never stale data.
                cfg_rdata_out <= cfg_err ? 32'h0000_0000
                                         : cfg_rdata_in;
            end
        end
    end

    // Requests always pass; bad identifiers are replaced by one set of defaults
    // shared by both security states.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            req_valid_out       <= 1'b0;
            req_ns_out          <= 1'b0;
            req_partition_out   <= `DEFAULT_PARTITION;
            req_group_out       <= `DEFAULT_GROUP;
            req_mon_exclude_out <= 1'b0;
        end else begin
            req_valid_out <= req_valid_in;
            if (req_valid_in) begin
                req_ns_out <= request_security_bit_in;
                if (rq_p_bad) begin
                    req_partition_out <= `DEFAULT_PARTITION;
                    req_group_out     <= `DEFAULT_GROUP;
                end else begin
                    req_partition_out <= request_partition_id_in;
                    req_group_out     <= rq_g_bad ? `DEFAULT_GROUP
                                                  : req_group_in;
                end
                req_mon_exclude_out <= !rq_p_bad && rq_g_bad;
            end
        end
    end

    assign error_status_register_s_out  = esr_s_r;
    assign error_status_register_ns_out = esr_ns_r;
    assign narrowing_present_out        = narrowing;

endmodule // msc_error_capture

// One banked status word. A software write and hardware errors in the same
// cycle are taken in order: the write first, then the errors, so an error
// is never lost to a clear. Two errors in one cycle count as an overwrite.
module msc_esr_bank #(
    parameter [31:0] RESET_VALUE = `ESR_RESET
) (
    input  wire        clk_sys_in,
    input  wire        rst_in,
    input  wire        sw_write_in,
    input  wire [31:0] sw_data_in,
    input  wire        cfg_hit_in,
    input  wire [31:0] cfg_synd_in,
    input  wire        req_hit_in,
    input  wire [31:0] req_synd_in,
    output wire [31:0] esr_nxt_out,
    output reg  [31:0] esr_out
);

    reg [31:0] base;
    reg        had_code;
    reg [31:0] esr_nxt;

    always @* begin
        base     = sw_write_in ? {sw_data_in[31], 3'h0, sw_data_in[27:0]}
                               : esr_out;
        had_code = (base[`ESR_CODE_HI:`ESR_CODE_LO] != `ERR_NONE) ||
                   (cfg_hit_in && req_hit_in);
        esr_nxt  = base;
        if (req_hit_in) begin
            esr_nxt               = req_synd_in;
            esr_nxt[`ESR_OVR_BIT] = had_code;
        end else if (cfg_hit_in) begin
            esr_nxt               = cfg_synd_in;
            esr_nxt[`ESR_OVR_BIT] = had_code;
        end
    end

    assign esr_nxt_out = esr_nxt;

    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            esr_out <= RESET_VALUE;
        end else begin
            esr_out <= esr_nxt;
        end
    end

endmodule // msc_esr_bank

//--- tb/msc_error_capture_checker.sv
// Port-level assertions for the error capture block.
// Assumes default limits and that the bench never lets a config error and a
// request error land in the same bank on the same cycle.
module msc_error_capture_checker #(
    parameter [15:0] PARTID_MAX_S  = 16'h00ff,
    parameter [15:0] PARTID_MAX_NS = 16'h00ff,
    parameter [7:0]  GROUP_MAX_S   = 8'h01,
    parameter [7:0]  GROUP_MAX_NS  = 8'h01,
    parameter [15:0] MONITOR_MAX   = 16'h0007
) (
    input wire        clk_sys_in, rst_in, cfg_valid_in, cfg_write_in,
    input wire        cfg_ns_in, selector_internal_in,
    input wire [1:0]  cfg_kind_in,
    input wire [15:0] partition_selector_in, monitor_index_field_in,
    input wire        cfg_done_out, cfg_apply_out, cfg_error_out,
    input wire [31:0] cfg_rdata_out,
    input wire        req_valid_in, request_security_bit_in,
    input wire [15:0] request_partition_id_in, req_partition_out,
    input wire [7:0]  req_group_in, req_group_out,
    input wire        req_valid_out, req_mon_exclude_out, esr_write_ns_in,
    input wire        error_irq_enable_s_in, error_irq_enable_ns_in,
    input wire [31:0] error_status_register_s_out,
    input wire [31:0] error_status_register_ns_out,
    input wire        error_irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    wire [31:0] s = error_status_register_s_out;
    wire [31:0] n = error_status_register_ns_out;
    wire [15:0] pmax = request_security_bit_in ? PARTID_MAX_NS : PARTID_MAX_S;
    wire [7:0]  gmax = request_security_bit_in ? GROUP_MAX_NS : GROUP_MAX_S;
    wire bad_p = req_valid_in && request_partition_id_in > pmax;
    wire bad_g = req_valid_in && !bad_p && req_group_in > gmax;
    wire cw = cfg_valid_in && cfg_write_in && cfg_ns_in;
    reg rq_ns_r;
    // The bank of a request is remembered so the bench may move the bit.
    always @(posedge clk_sys_in) rq_ns_r <= request_security_bit_in;
    wire [31:0] rq = rq_ns_r ? n : s;
    property p_answer;
        cfg_done_out == $past(cfg_valid_in) && req_valid_out == $past(req_valid_in);
    endproperty
    a_answer: assert property (p_answer) else $error("answer pulse");
    property p_req_part;
        bad_p |=> rq[30:0] == {7'h02, $past(req_group_in),
            $past(request_partition_id_in)} && req_partition_out == 16'h0000;
    endproperty
    a_req_part: assert property (p_req_part) else $error("req part");
    property p_req_grp;
        bad_g |=> req_mon_exclude_out && req_group_out == 8'h00 ##0
            rq[30:0] == {7'h04, $past(req_group_in), req_partition_out};
    endproperty
    a_req_grp: assert property (p_req_grp) else $error("req group");
    property p_sel;
        cw && cfg_kind_in == 2'h1 && selector_internal_in &&
            partition_selector_in > PARTID_MAX_NS |=> cfg_error_out &&
            !cfg_apply_out && n[30:0] == {15'h0100, $past(partition_selector_in)};
    endproperty
    a_sel: assert property (p_sel) else $error("selector range");
    property p_mon;
        cw && cfg_kind_in == 2'h3 && monitor_index_field_in > MONITOR_MAX
            |=> !cfg_apply_out && n[30:0] == {15'h0500, $past(monitor_index_field_in)};
    endproperty
    a_mon: assert property (p_mon) else $error("monitor range");
    property p_ovr;
        cfg_error_out && $past(cfg_ns_in) && !$past(esr_write_ns_in) &&
            ($past(n) & 32'h0f00_0000) != 32'h0 |-> n[31];
    endproperty
    a_ovr: assert property (p_ovr) else $error("overwrite flag");
    property p_no_ovr0;
        !$past(esr_write_ns_in) && $changed(n) |-> !(n[31] && n[27:24] == 4'h0);
    endproperty
    a_no_ovr0: assert property (p_no_ovr0) else $error("flag with no code");
    property p_irq;
        error_irq_out == (($past(error_irq_enable_s_in) && s[27:24] != 4'h0) ||
            ($past(error_irq_enable_ns_in) && n[27:24] != 4'h0));
    endproperty
    a_irq: assert property (p_irq) else $error("irq level");
    property p_rd_err;
        cfg_valid_in && !cfg_write_in && cfg_ns_in && cfg_kind_in == 2'h2 &&
            selector_internal_in |=> cfg_error_out && cfg_rdata_out == 32'h0 &&
            n[27:24] == 4'h7;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("map read");
endmodule // msc_error_capture_checker

bind msc_error_capture msc_error_capture_checker #(
    .PARTID_MAX_S(PARTID_MAX_S), .PARTID_MAX_NS(PARTID_MAX_NS),
    .GROUP_MAX_S(GROUP_MAX_S), .GROUP_MAX_NS(GROUP_MAX_NS),
    .MONITOR_MAX(MONITOR_MAX)
) msc_error_capture_checker_inst (.*);

//--- tb/cfg_store_model.sv
// Storage model behind the configuration port: supplies read data.
// Assumes an apply pulse marks each committed write.
module cfg_store_model (
    input  wire        clk_sys_in,
    input  wire        rst_in,
    input  wire        apply_in,
    output reg  [31:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Counting commits makes a dropped or an extra write visible on reads.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in)
            rdata_out <= 32'hc0de_0000;
        else if (apply_in)
            rdata_out <= rdata_out + 32'h1;
    end
endmodule // cfg_store_model

//--- tb/tb.sv
// Self-checking bench for the error capture block.
// Assumes default limits: partition 0xff, group 1, monitor 7, narrowing on.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk_sys_in = 1'b0, rst_in = 1'b1, cfg_valid_in = 1'b0;
    reg cfg_write_in = 1'b0, cfg_ns_in = 1'b1, selector_internal_in = 1'b0;
    reg map_internal_in = 1'b1, req_valid_in = 1'b0;
    reg request_security_bit_in = 1'b0, error_irq_enable_s_in = 1'b0;
    reg error_irq_enable_ns_in = 1'b1, esr_write_s_in = 1'b0;
    reg esr_write_ns_in = 1'b0;
    reg [1:0]  cfg_kind_in = 2'h0;
    reg [15:0] partition_selector_in = 16'h0, nval = 16'h0;
    reg [15:0] request_partition_id_in = 16'h0;
    reg [7:0]  mon_cfg_group_in = 8'h00, req_group_in = 8'h00;
    reg [31:0] esr_wdata_in = 32'h0;
    wire [31:0] cfg_rdata_in, cfg_rdata_out, st_s, st_ns;
    wire cfg_done_out, cfg_apply_out, cfg_error_out, req_valid_out;
    wire req_ns_out, req_mon_exclude_out, error_irq_out, narrowing_present_out;
    wire [15:0] req_partition_out;
    wire [7:0]  req_group_out;
    integer err_count = 0, n_tests = 0;
    always #2 clk_sys_in = ~clk_sys_in;
    msc_error_capture msc_error_capture_inst (.*,
        .narrowed_partition_field_in(nval), .mon_cfg_partition_in(nval),
        .monitor_index_field_in(partition_selector_in),
        .error_status_register_s_out(st_s), .error_status_register_ns_out(st_ns));
    cfg_store_model cfg_store_model_inst (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .apply_in(cfg_apply_out), .rdata_out(cfg_rdata_in));
    task chk_w(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t word %h expected %h", $time, g, e);
            end
        end
    endtask
    task chk_b(input g, input e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t flag %b expected %b", $time, g, e);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // The monitor index shares the selector value; kind decides which counts.
    task cfg(input [1:0] k, input w, input si, input [15:0] s, input [15:0] v);
        begin
            @(posedge clk_sys_in);
            cfg_kind_in <= k;
            cfg_write_in <= w;
            selector_internal_in <= si;
            partition_selector_in <= s;
            nval <= v;
            cfg_valid_in <= 1'b1;
            @(posedge clk_sys_in);
            cfg_valid_in <= 1'b0;
            #1;
        end
    endtask
    task req(input ns, input [15:0] p, input [7:0] g);
        begin
            @(posedge clk_sys_in);
            request_security_bit_in <= ns;
            request_partition_id_in <= p;
            req_group_in <= g;
            req_valid_in <= 1'b1;
            @(posedge clk_sys_in);
            req_valid_in <= 1'b0;
            #1;
        end
    endtask
    task clr;
        begin
            @(posedge clk_sys_in);
            esr_write_s_in <= 1'b1;
            esr_write_ns_in <= 1'b1;
            @(posedge clk_sys_in);
            esr_write_s_in <= 1'b0;
            esr_write_ns_in <= 1'b0;
            #1;
            chk_w(st_s | st_ns, 32'h0);
            chk_b(error_irq_out, 1'b0);
        end
    endtask
    task t_good;
        begin
            chk_b(narrowing_present_out, 1'b1);
            chk_w(st_ns, 32'h0);
            cfg(2'h1, 1'b1, 1'b1, 16'h0005, 16'h0);
            chk_b(cfg_apply_out & ~cfg_error_out & cfg_done_out, 1'b1);
            cfg(2'h0, 1'b0, 1'b1, 16'h0005, 16'h0);
            chk_w(cfg_rdata_out, 32'hc0de_0001);
        end
    endtask
    task t_sel;
        begin
            cfg(2'h1, 1'b1, 1'b1, 16'h0100, 16'h0);
            chk_b(cfg_error_out & ~cfg_apply_out, 1'b1);
            chk_w(st_ns, 32'h0100_0100);
            chk_b(error_irq_out, 1'b1);
            cfg(2'h3, 1'b1, 1'b1, 16'h0008, 16'h0);
            chk_b(cfg_apply_out, 1'b0);
            chk_w(st_ns, 32'h8500_0008);
            cfg(2'h0, 1'b0, 1'b1, 16'h0005, 16'h0);
            chk_w(cfg_rdata_out, 32'hc0de_0001);
            clr;
        end
    endtask
    task t_req;
        begin
            req(1'b0, 16'h0100, 8'h01);
            chk_b(req_valid_out, 1'b1);
            chk_w({8'h00, req_group_out, req_partition_out}, 32'h0);
            chk_w(st_s, 32'h0201_0100);
            chk_w(st_ns, 32'h0);
            chk_b(error_irq_out, 1'b0);
            req(1'b1, 16'h0005, 8'h02);
            chk_b(req_mon_exclude_out & req_ns_out, 1'b1);
            chk_w({8'h00, req_group_out, req_partition_out}, 32'h5);
            chk_w(st_ns, 32'h0402_0005);
            clr;
        end
    endtask
    task t_narrow;
        begin
            cfg(2'h2, 1'b0, 1'b1, 16'h0003, 16'h0);
            chk_w(cfg_rdata_out, 32'h0);
            chk_w(st_ns, 32'h0700_0003);
            map_internal_in <= 1'b0;
            cfg(2'h2, 1'b1, 1'b0, 16'h0003, 16'h0005);
            map_internal_in <= 1'b1;
            chk_w(st_ns, 32'h8600_0005);
            cfg(2'h1, 1'b0, 1'b0, 16'h0007, 16'h0);
            chk_w(st_ns, 32'h8600_0007);
            cfg_ns_in <= 1'b0;
            mon_cfg_group_in <= 8'h01;
            cfg(2'h3, 1'b1, 1'b1, 16'h0002, 16'h0100);
            chk_w(st_s, 32'h0301_0100);
            chk_b(st_s[27] | st_ns[27], 1'b0);
            clr;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        t_good;
        t_sel;
        t_req;
        t_narrow;
        end_of_test;
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #20000;
        err_count = err_count + 1;
        end_of_test;
    end
endmodule // tb
